// ==== pkg/das_regs.svh ====
/*
  Constants for the touch-tone command and alarm supervisor.
  Assumes a 20 MHz mclk; times are in milliseconds.
*/
`ifndef DAS_REGS_SVH
`define DAS_REGS_SVH

`define DAS_CLK_KHZ      20000
`define DAS_MS2CYC(ms)   ((ms) * `DAS_CLK_KHZ)
`define DAS_PWRUP_MS     5000
`define DAS_REFDLY_MS    2000
`define DAS_VALID_MS     1000
`define DAS_FIXDLY_MS    3000
`define DAS_FIX_TRIES    2'd3

`define DAS_KEY_STAR     4'ha
`define DAS_KEY_POUND    4'hb
`define DAS_DIGIT_MAX    4'h9

`define DAS_CODE_SCAN    7'h00
`define DAS_CODE_METER   7'h4d
`define DAS_CODE_STATUS  7'h58
`define DAS_CODE_CHMAX   7'h20

`endif

// ==== pkg/das_pkg.sv ====
/*
  Types for the touch-tone command and alarm supervisor.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package das_pkg;
  typedef enum logic [1:0] {
    DAS_RPT_BOTH,
    DAS_RPT_METER,
    DAS_RPT_STATUS
  } das_rpt_t;

  typedef enum logic [1:0] {
    DAS_CMD_IDLE,
    DAS_CMD_ANN,
    DAS_CMD_SCAN,
    DAS_CMD_SCAN_WAIT
  } das_cmd_st_t;

  typedef enum logic {
    DAS_FIX_IDLE,
    DAS_FIX_WAIT
  } das_fix_st_t;
endpackage
`default_nettype wire

// ==== rtl/das_digit_pair.sv ====
/*
  Collects decoded tones into two-digit codes and key events.
  Assumes digit_valid is a one-cycle pulse on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "das_regs.svh"
module das_digit_pair (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       digit_valid,
  input  wire logic [3:0] digit_code,
  output logic            code_valid,
  output logic [6:0]      code,
  output logic            raise_key,
  output logic            lower_key
);
  typedef struct packed {
    logic       have;
    logic [3:0] first;
    logic       cv;
    logic [6:0] code;
    logic       raise;
    logic       lower;
  } das_dp_t;

  das_dp_t s_q, s_d;

  always_comb begin
    s_d       = s_q;
    s_d.cv    = 1'b0;
    s_d.raise = 1'b0;
    s_d.lower = 1'b0;
    if (digit_valid) begin
      if (digit_code == `DAS_KEY_STAR) begin
        s_d.raise = 1'b1;
        s_d.have  = 1'b0;
      end else if (digit_code == `DAS_KEY_POUND) begin
        s_d.lower = 1'b1;
        s_d.have  = 1'b0;
      end else if (digit_code <= `DAS_DIGIT_MAX) begin
        if (s_q.have) begin
          s_d.cv   = 1'b1;
          s_d.code = 7'({3'h0, s_q.first} * 7'h0a + {3'h0, digit_code});
          s_d.have = 1'b0;
        end else begin
          s_d.first = digit_code;
          s_d.have  = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign code_valid = s_q.cv;
  assign code       = s_q.code;
  assign raise_key  = s_q.raise;
  assign lower_key  = s_q.lower;
endmodule
`default_nettype wire

// ==== rtl/das_alarm_qual.sv ====
/*
  Per-channel synchroniser and alarm validation timer.
  Assumes oot_pin is asynchronous; hold comes from mclk logic.
*/
`timescale 1ns/1ps
`default_nettype none
module das_alarm_qual #(
  parameter int N       = 32,
  parameter int CW      = 32,
  parameter int VAL_CYC = 20000000
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic [N-1:0] oot_pin,
  input  wire logic         hold,
  output logic [N-1:0]      oot_lvl,
  output logic [N-1:0]      active,
  output logic [N-1:0]      rise
);
  typedef struct packed {
    logic [N-1:0]         s1;
    logic [N-1:0]         s2;
    logic [N-1:0]         act;
    logic [N-1:0]         rise;
    logic [N-1:0][CW-1:0] cnt;
  } das_aq_t;

  das_aq_t s_q, s_d;

  always_comb begin
    s_d    = s_q;
    s_d.s1 = oot_pin;
    s_d.s2 = s_q.s1;
    for (int i = 0; i < N; i++) begin
      // Reference window discards any partial qualification
      if (hold || !s_q.s2[i]) begin
        s_d.cnt[i] = '0;
        s_d.act[i] = 1'b0;
      end else if (s_q.cnt[i] >= CW'(VAL_CYC - 1)) begin
        s_d.act[i] = 1'b1;
      end else begin
        s_d.cnt[i] = s_q.cnt[i] + CW'(1);
      end
    end
    s_d.rise = s_d.act & ~s_q.act;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign oot_lvl = s_q.s2;
  assign active  = s_q.act;
  assign rise    = s_q.rise;
endmodule
`default_nettype wire

// ==== rtl/dtmf_alarm_supervisor.sv ====
/*
  Touch-tone command interpreter and alarm manager for a site
  controller. Assumes tone events, speech handshake, dialer status
  and channel configuration levels all come from mclk logic; only
  the out-of-tolerance inputs are asynchronous pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "das_regs.svh"
// Operation
// (R1) Code 00 announces every scan-listed channel, skipping the others.
// (R2) Codes 01..32 select that channel and announce meter and status.
// (R3) Any tone while speaking stops speech at once.
// (R4) Star pulses raise relay, pound pulses lower relay, current channel.
// (R5) Code 77 announces only the current meter; needs a selection.
// (R6) Code 88 announces only the current status; needs a selection.
// (R7) Action plus critical together: dial, stack action, no correction.
// (R8) Simultaneous action alarms corrected lowest channel first.
// (R9) No correction while any reported alarm is active.
// (R10) Every new alarm is pushed onto the new-alarm stack; the code never stacks an alarm that correction clears.
// (R11) Each recurrence after recovery is a separate alarm event.
// (R12) Critical alarm after previous dial-out ends dials again.
// (R13) Critical alarms during a dial-out are stacked, not dialled.
// (R14) Up to three corrections, then stack and stop until recovery.
// (R15) Warning without corrective action is stacked immediately.
// (R16) Relay operation starts fresh reference and ignores alarms.
// (R17) Reference delay after relay or hangup before alarm checks.
// (R18) Alarm active only after validation time out of tolerance.
// (R19) Fix delay after each correction before rechecking.
// (R20) Digits pair into codes; readback without selection ignored.
module dtmf_alarm_supervisor #(
  parameter int N         = 32,
  parameter int CW        = 32,
  parameter int PWRUP_CYC = `DAS_MS2CYC(`DAS_PWRUP_MS),
  parameter int REF_CYC   = `DAS_MS2CYC(`DAS_REFDLY_MS),
  parameter int VAL_CYC   = `DAS_MS2CYC(`DAS_VALID_MS),
  parameter int FIX_CYC   = `DAS_MS2CYC(`DAS_FIXDLY_MS)
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         digit_valid,
  input  wire logic [3:0]   digit_code,
  input  wire logic         speaking,
  input  wire logic         announce_done,
  input  wire logic         hangup,
  input  wire logic         dial_busy,
  input  wire logic [N-1:0] oot_pin,
  input  wire logic [N-1:0] scan_en,
  input  wire logic [N-1:0] report_en,
  input  wire logic [N-1:0] action_en,
  input  wire logic [N-1:0] critical_en,
  output logic              speak_stop,
  output logic              announce_valid,
  output logic [4:0]        announce_chan,
  output das_pkg::das_rpt_t announce_kind,
  output logic              relay_raise,
  output logic              relay_lower,
  output logic [4:0]        relay_chan,
  output logic              fix_start,
  output logic [4:0]        fix_chan,
  output logic              dial_start,
  output logic [4:0]        dial_chan,
  output logic              stack_push,
  output logic [4:0]        stack_chan,
  output logic              stack_crit,
  output logic              ref_busy
);
  typedef struct packed {
    das_pkg::das_cmd_st_t cmd;
    logic                 sel;
    logic [4:0]           cur;
    logic [4:0]           idx;
    logic                 stop;
    logic                 ann_v;
    logic [4:0]           ann_ch;
    das_pkg::das_rpt_t    ann_kind;
    logic                 r_up;
    logic                 r_dn;
    logic [4:0]           r_ch;
    logic [CW-1:0]        ref_cnt;
    logic                 ref_busy;
    logic [N-1:0]         push_pend;
    logic                 push;
    logic [4:0]           push_ch;
    logic                 push_crit;
    logic [N-1:0]         fix_pend;
    logic [N-1:0]         give_up;
    das_pkg::das_fix_st_t fix_st;
    logic [4:0]           fix_ch;
    logic [1:0]           tries;
    logic [CW-1:0]        fix_cnt;
    logic                 fix_go;
    logic                 dial_v;
    logic [4:0]           dial_ch;
  } das_top_t;

  das_top_t     s_q, s_d;
  logic         code_valid;
  logic [6:0]   code;
  logic         raise_key;
  logic         lower_key;
  logic [N-1:0] oot_lvl;
  logic [N-1:0] active;
  logic [N-1:0] rise;
  logic [N-1:0] new_crit;
  logic [N-1:0] new_fix;
  logic         act_rep;

  // Channel numbers are five bits wide, so N must not exceed 32
  function automatic logic [4:0] das_lsb(input logic [N-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  das_digit_pair u_pair (
    .mclk        (mclk),
    .resetn      (resetn),
    .digit_valid (digit_valid),
    .digit_code  (digit_code),
    .code_valid  (code_valid),
    .code        (code),
    .raise_key   (raise_key),
    .lower_key   (lower_key)
  );

  // (R18) validation timer per channel
  das_alarm_qual #(
    .N       (N),
    .CW      (CW),
    .VAL_CYC (VAL_CYC)
  ) u_qual (
    .mclk    (mclk),
    .resetn  (resetn),
    .oot_pin (oot_pin),
    .hold    (s_q.ref_busy),
    .oot_lvl (oot_lvl),
    .active  (active),
    .rise    (rise)
  );

  assign act_rep  = |(active & report_en);
  assign new_crit = rise & critical_en;
  // (R7) simultaneous critical suppresses correction
  assign new_fix  = (|new_crit) ? '0
                  : (rise & action_en & ~critical_en & ~s_q.give_up);

  always_comb begin
    s_d        = s_q;
    s_d.stop   = 1'b0;
    s_d.ann_v  = 1'b0;
    s_d.r_up   = 1'b0;
    s_d.r_dn   = 1'b0;
    s_d.push   = 1'b0;
    s_d.fix_go = 1'b0;
    s_d.dial_v = 1'b0;

    // (R3) any tone silences speech and aborts announcing
    if (digit_valid) begin
      s_d.stop = speaking;
      s_d.cmd  = das_pkg::DAS_CMD_IDLE;
    end else begin
      case (s_q.cmd)
        das_pkg::DAS_CMD_ANN: begin
          if (announce_done) begin
            s_d.cmd = das_pkg::DAS_CMD_IDLE;
          end
        end
        // (R1) walk scan list, skipping unlisted channels
        das_pkg::DAS_CMD_SCAN: begin
          if (scan_en[s_q.idx]) begin
            s_d.ann_v    = 1'b1;
            s_d.ann_ch   = s_q.idx;
            s_d.ann_kind = das_pkg::DAS_RPT_BOTH;
            s_d.cmd      = das_pkg::DAS_CMD_SCAN_WAIT;
          end else if (s_q.idx == 5'(N - 1)) begin
            s_d.cmd = das_pkg::DAS_CMD_IDLE;
          end else begin
            s_d.idx = s_q.idx + 5'h01;
          end
        end
        das_pkg::DAS_CMD_SCAN_WAIT: begin
          if (announce_done) begin
            if (s_q.idx == 5'(N - 1)) begin
              s_d.cmd = das_pkg::DAS_CMD_IDLE;
            end else begin
              s_d.idx = s_q.idx + 5'h01;
              s_d.cmd = das_pkg::DAS_CMD_SCAN;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // (R20) paired codes; readback needs a selection
    if (code_valid) begin
      if (code == `DAS_CODE_SCAN) begin
        s_d.idx = 5'h00;
        s_d.cmd = das_pkg::DAS_CMD_SCAN;
      end else if (code <= `DAS_CODE_CHMAX) begin
        // (R2) select and report both readings
        s_d.sel      = 1'b1;
        s_d.cur      = 5'(code - 7'h01);
        s_d.ann_v    = 1'b1;
        s_d.ann_ch   = 5'(code - 7'h01);
        s_d.ann_kind = das_pkg::DAS_RPT_BOTH;
        s_d.cmd      = das_pkg::DAS_CMD_ANN;
      end else if (s_q.sel && (code == `DAS_CODE_METER
                               || code == `DAS_CODE_STATUS)) begin
        // (R5) meter only; (R6) status only
        s_d.ann_v    = 1'b1;
        s_d.ann_ch   = s_q.cur;
        s_d.ann_kind = (code == `DAS_CODE_METER) ? das_pkg::DAS_RPT_METER
                                                  : das_pkg::DAS_RPT_STATUS;
        s_d.cmd      = das_pkg::DAS_CMD_ANN;
      end
    end

    // (R4) relays act on the current channel only
    if (s_q.sel) begin
      s_d.r_up = raise_key;
      s_d.r_dn = lower_key;
      s_d.r_ch = s_q.cur;
    end

    // (R13) one dial-out at a time, later criticals only stacked
    if (|new_crit && !dial_busy && !s_q.dial_v) begin
      // (R12) a finished dial-out lets a repeat dial again
      s_d.dial_v  = 1'b1;
      s_d.dial_ch = das_lsb(new_crit);
    end

    // Correction sequencer, one channel at a time
    case (s_q.fix_st)
      das_pkg::DAS_FIX_IDLE: begin
        if (|s_q.fix_pend) begin
          s_d.fix_ch = das_lsb(s_q.fix_pend);
          if (!oot_lvl[s_d.fix_ch]) begin
            // (R8) lowest pending channel dropped once it has cleared
            s_d.fix_pend[s_d.fix_ch] = 1'b0;
            s_d.tries                = 2'd0;
          // (R9) withheld while a reported alarm is active
          end else if (!report_en[s_d.fix_ch] && !act_rep) begin
            s_d.fix_go  = 1'b1;
            s_d.fix_cnt = CW'(FIX_CYC);
            s_d.fix_st  = das_pkg::DAS_FIX_WAIT;
          end
        end
      end
      das_pkg::DAS_FIX_WAIT: begin
        // (R19) recheck only after the fix delay
        if (s_q.fix_cnt > CW'(1)) begin
          s_d.fix_cnt = s_q.fix_cnt - CW'(1);
        end else begin
          s_d.fix_st = das_pkg::DAS_FIX_IDLE;
          if (!oot_lvl[s_q.fix_ch]) begin
            s_d.fix_pend[s_q.fix_ch] = 1'b0;
            s_d.tries                = 2'd0;
          end else if (s_q.tries + 2'd1 == `DAS_FIX_TRIES) begin
            // (R14) give up and stack after the last try
            s_d.fix_pend[s_q.fix_ch]  = 1'b0;
            s_d.give_up[s_q.fix_ch]   = 1'b1;
            s_d.push_pend[s_q.fix_ch] = 1'b1;
            s_d.tries                 = 2'd0;
          end else begin
            s_d.tries = s_q.tries + 2'd1;
          end
        end
      end
      default: begin
        s_d.fix_st = das_pkg::DAS_FIX_IDLE;
      end
    endcase

    // Recovery re-arms correction for the next failure
    s_d.give_up = s_d.give_up & oot_lvl;

    // One stack entry per cycle, lowest channel first
    if (|s_q.push_pend) begin
      s_d.push      = 1'b1;
      s_d.push_ch   = das_lsb(s_q.push_pend);
      s_d.push_crit = critical_en[s_d.push_ch];
      s_d.push_pend[s_d.push_ch] = 1'b0;
    end
    // (R10) new alarms stacked unless queued for correction; (R15) no-action ones at once
    // (R11) each rise is a fresh event; set wins over clear
    s_d.push_pend = s_d.push_pend | (rise & ~new_fix);
    s_d.fix_pend  = s_d.fix_pend | new_fix;

    // (R16) relay or fix restarts reference; (R17) so does hangup
    if (s_d.r_up || s_d.r_dn || s_d.fix_go || hangup) begin
      s_d.ref_cnt = CW'(REF_CYC);
    end else if (s_q.ref_cnt != '0) begin
      s_d.ref_cnt = s_q.ref_cnt - CW'(1);
    end
    s_d.ref_busy = (s_d.ref_cnt != '0);
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_q          <= '0;
      s_q.ref_cnt  <= CW'(PWRUP_CYC);
      s_q.ref_busy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign speak_stop     = s_q.stop;
  assign announce_valid = s_q.ann_v;
  assign announce_chan  = s_q.ann_ch;
  assign announce_kind  = s_q.ann_kind;
  assign relay_raise    = s_q.r_up;
  assign relay_lower    = s_q.r_dn;
  assign relay_chan     = s_q.r_ch;
  assign fix_start      = s_q.fix_go;
  assign fix_chan       = s_q.fix_ch;
  assign dial_start     = s_q.dial_v;
  assign dial_chan      = s_q.dial_ch;
  assign stack_push     = s_q.push;
  assign stack_chan     = s_q.push_ch;
  assign stack_crit     = s_q.push_crit;
  assign ref_busy       = s_q.ref_busy;

  default clocking das_cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence meter_req;
    code_valid && !digit_valid && s_q.sel && code == `DAS_CODE_METER;
  endsequence
  sequence status_req;
    code_valid && !digit_valid && s_q.sel && code == `DAS_CODE_STATUS;
  endsequence
  sequence blind_req;
    code_valid && !s_q.sel
      && (code == `DAS_CODE_METER || code == `DAS_CODE_STATUS);
  endsequence

  stop_on_tone_a: assert property ( // (R3)
    digit_valid && speaking |=> speak_stop)
    else $error("speech not stopped by tone");

  select_report_a: assert property ( // (R2)
    code_valid && code != 7'h00 && code <= `DAS_CODE_CHMAX
      |=> announce_valid && announce_chan == 5'($past(code) - 7'h01)
          && announce_kind == das_pkg::DAS_RPT_BOTH)
    else $error("channel select not reported");

  meter_only_a: assert property ( // (R5)
    meter_req |=> announce_valid
      && announce_kind == das_pkg::DAS_RPT_METER)
    else $error("meter readback missing");

  status_only_a: assert property ( // (R6)
    status_req |=> announce_valid
      && announce_kind == das_pkg::DAS_RPT_STATUS)
    else $error("status readback missing");

  blind_read_a: assert property ( // (R20)
    blind_req |=> !announce_valid ##1 !announce_valid)
    else $error("readback without selection answered");

  scan_list_a: assert property ( // (R1)
    announce_valid && s_q.cmd == das_pkg::DAS_CMD_SCAN_WAIT
      |-> scan_en[announce_chan])
    else $error("scan announced unlisted channel");

  relay_ref_a: assert property ( // (R16)
    (relay_raise || relay_lower) |-> ref_busy [*3])
    else $error("relay did not start reference delay");

  dial_single_a: assert property ( // (R13)
    dial_start |-> !$past(dial_busy) && !$past(dial_start))
    else $error("dial started during dial-out");

  fix_withhold_a: assert property ( // (R9)
    fix_start |-> !$past(act_rep))
    else $error("correction while alarm active");

  fix_delay_a: assert property ( // (R19)
    fix_start |=> !fix_start [*8])
    else $error("correction repeated before fix delay");

  tries_bound_a: assert property ( // (R14)
    s_q.tries < `DAS_FIX_TRIES)
    else $error("correction tries exceeded");
endmodule
`default_nettype wire

// ==== tb/das_caller.sv ====
/*
  Telephone caller model: presses touch-tone keys on request.
  Assumes the bench calls its tasks; keys change at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module das_caller (
  input  wire logic  mclk,
  output logic       digit_valid,
  output logic [3:0] digit_code
);
  initial begin
    digit_valid = 1'b0;
    digit_code  = 4'h0;
  end

  // Idle code is inverted so a stale digit never looks valid
  task automatic key(input logic [3:0] d, input int gap);
    @(negedge mclk);
    digit_valid = 1'b1;
    digit_code  = d;
    @(negedge mclk);
    digit_valid = 1'b0;
    digit_code  = ~d;
    repeat (gap) @(negedge mclk);
  endtask

  task automatic code(input int c, input int gap);
    key(4'(c / 10), 0);
    key(4'(c % 10), gap);
  endtask
endmodule
`default_nettype wire

// ==== tb/dtmf_alarm_supervisor_tb.sv ====
/*
  Self-checking bench for the touch-tone supervisor.
  Assumes short timer parameters; inputs change at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module dtmf_alarm_supervisor_tb;
  logic mclk, resetn, digit_valid, speaking, announce_done, hangup;
  logic dial_busy, speak_stop, announce_valid, relay_raise;
  logic relay_lower, fix_start, dial_start, stack_push, stack_crit;
  logic ref_busy, dial_rel;
  logic [3:0]  digit_code;
  logic [31:0] oot_pin, scan_en, report_en, action_en, critical_en;
  logic [4:0]  announce_chan, relay_chan, fix_chan, dial_chan;
  logic [4:0]  stack_chan, l_ann, l_rel, l_fix, l_dial, l_push;
  logic        l_crit;
  das_pkg::das_rpt_t announce_kind, l_kind;
  int n_ann, n_stop, n_rse, n_low, n_fix, n_dial, n_push;
  int mismatches, n_compared, b;

  das_caller u_das_caller (.mclk(mclk), .digit_valid(digit_valid),
    .digit_code(digit_code));

  dtmf_alarm_supervisor #(.PWRUP_CYC(20), .REF_CYC(20), .VAL_CYC(10),
    .FIX_CYC(12)) u_dtmf_alarm_supervisor (
    .mclk(mclk), .resetn(resetn), .digit_valid(digit_valid),
    .digit_code(digit_code), .speaking(speaking),
    .announce_done(announce_done), .hangup(hangup),
    .dial_busy(dial_busy), .oot_pin(oot_pin), .scan_en(scan_en),
    .report_en(report_en), .action_en(action_en),
    .critical_en(critical_en), .speak_stop(speak_stop),
    .announce_valid(announce_valid), .announce_chan(announce_chan),
    .announce_kind(announce_kind), .relay_raise(relay_raise),
    .relay_lower(relay_lower), .relay_chan(relay_chan),
    .fix_start(fix_start), .fix_chan(fix_chan),
    .dial_start(dial_start), .dial_chan(dial_chan),
    .stack_push(stack_push), .stack_chan(stack_chan),
    .stack_crit(stack_crit), .ref_busy(ref_busy));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Tally pulses mid-cycle, clear of the launching edge
  always @(negedge mclk) begin
    if (announce_valid === 1'b1) begin
      n_ann++;
      l_ann = announce_chan;
      l_kind = announce_kind;
    end
    if (speak_stop === 1'b1) n_stop++;
    if (relay_raise === 1'b1) n_rse++;
    if (relay_lower === 1'b1) n_low++;
    if (relay_raise === 1'b1 || relay_lower === 1'b1) l_rel = relay_chan;
    if (fix_start === 1'b1) begin
      n_fix++;
      l_fix = fix_chan;
    end
    if (dial_start === 1'b1) begin
      n_dial++;
      l_dial = dial_chan;
      dial_busy = 1'b1;
    end else if (resetn !== 1'b1 || dial_rel === 1'b1) begin
      // Dialer model owns dial_busy; the bench only releases it
      dial_busy = 1'b0;
    end
    if (stack_push === 1'b1) begin
      n_push++;
      l_push = stack_chan;
      l_crit = stack_crit;
    end
  end

  task automatic chk_val(input logic [4:0] got, input logic [4:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for a tally to reach a target
  task automatic wait_for(ref int c, input int tgt, input int lim);
    for (int i = 0; i < lim && c < tgt; i++) @(posedge mclk);
  endtask

  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask

  task automatic wait_quiet;
    for (int i = 0; i < 200 && ref_busy !== 1'b0; i++) @(posedge mclk);
  endtask

  task automatic t_refuse;
    u_das_caller.code(77, 10);
    u_das_caller.key(4'ha, 10);
    chk_cnt(n_ann, 0);
    chk_cnt(n_rse, 0);
  endtask

  task automatic t_select;
    u_das_caller.code(5, 0);
    wait_for(n_ann, 1, 20);
    chk_val(l_ann, 5'h4);
    chk_val(5'(l_kind), 5'(das_pkg::DAS_RPT_BOTH));
    u_das_caller.code(88, 0);
    wait_for(n_ann, 2, 20);
    chk_val(5'(l_kind), 5'(das_pkg::DAS_RPT_STATUS));
    u_das_caller.code(77, 0);
    wait_for(n_ann, 3, 20);
    chk_val(5'(l_kind), 5'(das_pkg::DAS_RPT_METER));
    chk_val(l_ann, 5'h4);
  endtask

  task automatic t_relay;
    u_das_caller.key(4'ha, 2);
    chk_cnt(n_rse, 1);
    chk_val(l_rel, 5'h4);
    chk_val({4'h0, ref_busy}, 5'h1);
    u_das_caller.key(4'hb, 2);
    chk_cnt(n_low, 1);
    wait_quiet;
    pulse(hangup);
    @(negedge mclk);
    chk_val({4'h0, ref_busy}, 5'h1);
    wait_quiet;
    chk_val({4'h0, ref_busy}, 5'h0);
  endtask

  task automatic t_stop;
    @(negedge mclk);
    speaking = 1'b1;
    u_das_caller.code(3, 1);
    chk_cnt(n_stop, 2);
    speaking = 1'b0;
    wait_for(n_ann, 4, 20);
    chk_val(l_ann, 5'h2);
  endtask

  task automatic t_scan;
    logic [4:0] exp[3] = '{5'h1, 5'h3, 5'h1f};
    @(negedge mclk);
    scan_en = 32'h8000000a;
    u_das_caller.code(0, 0);
    for (int k = 0; k < 3; k++) begin
      wait_for(n_ann, 5 + k, 40);
      chk_val(l_ann, exp[k]);
      pulse(announce_done);
    end
    repeat (30) @(posedge mclk);
    chk_cnt(n_ann, 7);
  endtask

  task automatic t_warn;
    @(negedge mclk);
    oot_pin[6] = 1'b1;
    repeat (8) @(posedge mclk);
    chk_cnt(n_push, 0);
    wait_for(n_push, 1, 30);
    chk_val(l_push, 5'h6);
    chk_val({4'h0, l_crit}, 5'h0);
    @(negedge mclk);
    oot_pin[6] = 1'b0;
  endtask

  task automatic t_crit;
    @(negedge mclk);
    critical_en[3:2] = 2'h3;
    oot_pin[2] = 1'b1;
    wait_for(n_dial, 1, 40);
    chk_val(l_dial, 5'h2);
    wait_for(n_push, 2, 10);
    chk_val(l_push, 5'h2);
    chk_val({4'h0, l_crit}, 5'h1);
    @(negedge mclk);
    oot_pin[3] = 1'b1;
    wait_for(n_push, 3, 40);
    chk_val(l_push, 5'h3);
    chk_cnt(n_dial, 1);
    @(negedge mclk);
    dial_rel = 1'b1;
    oot_pin[3:2] = 2'h0;
    repeat (6) @(negedge mclk);
    oot_pin[2] = 1'b1;
    wait_for(n_push, 4, 40);
    chk_val(l_push, 5'h2);
    chk_cnt(n_dial, 2);
    chk_val(l_dial, 5'h2);
    @(negedge mclk);
    oot_pin[2] = 1'b0;
    critical_en = '0;
  endtask

  task automatic t_fix;
    @(negedge mclk);
    report_en[9] = 1'b0;
    action_en[9] = 1'b1;
    repeat (6) @(negedge mclk);
    oot_pin[9] = 1'b1;
    wait_for(n_push, 5, 800);
    chk_cnt(n_fix, 3);
    chk_val(l_fix, 5'h9);
    chk_val(l_push, 5'h9);
    repeat (200) @(negedge mclk);
    chk_cnt(n_fix, 3);
    oot_pin[9] = 1'b0;
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    results;
  end

  initial begin
    resetn = 1'b0;
    {speaking, announce_done, hangup, dial_rel} = 4'h0;
    {oot_pin, scan_en, action_en, critical_en} = '0;
    report_en = '1;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    t_refuse;
    t_select;
    t_relay;
    t_stop;
    t_scan;
    wait_quiet;
    t_warn;
    t_crit;
    t_fix;
    results;
  end
endmodule
`default_nettype wire
